// ===== hdl/bvp_pkg.sv
// Constants for the boot strap status and port group clock select registers.
// Assumes a single 100 MHz core clock and a plain strobe register port.
`default_nettype none
package bvp_pkg;
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          NUM_GROUPS     = 8;
  localparam int          NUM_PORTS      = 24;
  localparam int          SEL_W          = 2;
  localparam int          STRAP_W        = 24;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] OFS_STATUS     = 12'h004;
  localparam logic [11:0] OFS_CLK_SEL    = 12'h008;

  // ****************************************
  // Boot strap status field positions
  // ****************************************
  localparam int          MODE_LSB       = 0;
  localparam int          MODE_W         = 4;
  localparam int          FSEL_BIT       = 5;
  localparam int          SADDR_LSB      = 7;
  localparam int          SADDR_W        = 2;
  localparam int          HOLD_BIT       = 9;
  localparam int          SCHEME_LSB     = 14;
  localparam int          SCHEME_W       = 2;
  localparam int          STK0_LSB       = 16;
  localparam int          STK1_LSB       = 18;
  localparam int          STK01_W        = 2;
  localparam int          STK2_LSB       = 20;
  localparam int          STK3_LSB       = 25;
  localparam int          STK23_W        = 5;

  // ****************************************
  // Clock select encodings and reset value
  // ****************************************
  localparam logic [1:0]  SEL_GLOBAL     = 2'h0;
  localparam logic [1:0]  SEL_LOCAL      = 2'h1;
  localparam logic [15:0] CLK_SEL_RESET  = 16'h0000;
  localparam int          CLK_SEL_W      = 16;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  typedef enum logic [1:0] {
    BVP_FETCH_IDLE,
    BVP_FETCH_CAPTURE,
    BVP_FETCH_DONE
  } bvp_fetch_state_t;
endpackage : bvp_pkg
`default_nettype wire

// ===== hdl/bvp_cfg_if.sv
// Carries the register write path and captured straps between the modules.
// Assumes all members are in the core clock domain.
`default_nettype none
interface bvp_cfg_if;
  logic                                      wr_en;
  logic [bvp_pkg::CLK_SEL_W-1:0]             wr_data;
  logic [bvp_pkg::CLK_SEL_W-1:0]             clk_sel;
  logic [bvp_pkg::STRAP_W-1:0]               straps;
  logic                                      straps_valid;
  modport regs   (input wr_en, input wr_data, output clk_sel);
  modport master (output wr_en, output wr_data, input clk_sel);
  modport cap    (output straps, output straps_valid);
  modport use_   (input straps, input straps_valid);
endinterface : bvp_cfg_if
`default_nettype wire

// ===== hdl/bvp_strap_capture.sv
// Captures the boot straps once after fundamental reset release.
// Assumes straps are stable and synchronous to the core clock at release.
`default_nettype none
module bvp_strap_capture (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic [bvp_pkg::STRAP_W-1:0] i_straps,
  bvp_cfg_if.cap    cfg
);
  bvp_pkg::bvp_fetch_state_t state;

  // Reset loads constants only; the strap level is taken on the first clock edge after release
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= bvp_pkg::BVP_FETCH_IDLE;
    end else begin
      case (state)
        bvp_pkg::BVP_FETCH_IDLE:    state <= bvp_pkg::BVP_FETCH_CAPTURE;
        bvp_pkg::BVP_FETCH_CAPTURE: state <= bvp_pkg::BVP_FETCH_DONE;
        bvp_pkg::BVP_FETCH_DONE:    state <= bvp_pkg::BVP_FETCH_DONE;
        default:                    state <= bvp_pkg::BVP_FETCH_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg.straps <= '0;
    end else if (state == bvp_pkg::BVP_FETCH_IDLE) begin
      cfg.straps <= i_straps;
    end
  end

  assign cfg.straps_valid = (state != bvp_pkg::BVP_FETCH_IDLE);
endmodule : bvp_strap_capture
`default_nettype wire

// ===== hdl/bvp_clock_select.sv
// Holds the port group clock select fields.
// Assumes only fundamental reset reaches i_rst_n; soft resets never do.
`default_nettype none
module bvp_clock_select (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  bvp_cfg_if.regs   cfg
);
  // Fields are sticky: no soft reset input exists, so only fundamental reset clears them
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg.clk_sel <= bvp_pkg::CLK_SEL_RESET;
    end else if (cfg.wr_en) begin
      cfg.clk_sel <= cfg.wr_data;
    end
  end
endmodule : bvp_clock_select
`default_nettype wire

// ===== hdl/bvp_regs.sv
// Boot strap status and port group clock select register bank.
// Assumes straps are stable during and just after fundamental reset, and a
// register master that follows the plain strobe protocol on the core clock.
//
// Our own choice: the strobed register port.
`default_nettype none
module bvp_regs (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_n,
  input  wire logic [3:0]                    i_switch_operating_mode,
  input  wire logic                          i_global_clock_freq_select,
  input  wire logic [1:0]                    i_mgmt_slave_address,
  input  wire logic                          i_reset_hold_strap,
  input  wire logic [1:0]                    i_ref_clock_scheme,
  input  wire logic [1:0]                    i_stack0_initial_config,
  input  wire logic [1:0]                    i_stack1_initial_config,
  input  wire logic [4:0]                    i_stack2_initial_config,
  input  wire logic [4:0]                    i_stack3_initial_config,
  input  wire logic                          i_reset_hold_release,
  input  wire logic [bvp_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [bvp_pkg::DATA_W-1:0]    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [bvp_pkg::DATA_W-1:0]    o_rdata,
  output logic      [bvp_pkg::NUM_PORTS-1:0] o_port_local_clock,
  output logic                               o_switch_hold
);
  bvp_cfg_if cfg ();

  logic [bvp_pkg::DATA_W-1:0]  status_word;
  logic [bvp_pkg::DATA_W-1:0]  next_rdata;
  logic                        hold;

  // ****************************************
  // Strap capture
  // ****************************************
  bvp_strap_capture u_cap (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_straps   ({i_stack3_initial_config, i_stack2_initial_config,
                  i_stack1_initial_config, i_stack0_initial_config,
                  i_ref_clock_scheme, i_reset_hold_strap, i_mgmt_slave_address,
                  i_global_clock_freq_select, i_switch_operating_mode}),
    .cfg        (cfg.cap)
  );

  // ****************************************
  // Status word assembly
  // ****************************************
  logic [bvp_pkg::STRAP_W-1:0] s;
  assign s = cfg.straps;

  always_comb begin
    status_word = bvp_pkg::ZERO_WORD;
    status_word[bvp_pkg::MODE_LSB +: bvp_pkg::MODE_W] = s[3:0];
    status_word[bvp_pkg::FSEL_BIT] = s[4];
    status_word[bvp_pkg::SADDR_LSB +: bvp_pkg::SADDR_W] = s[6:5];
    status_word[bvp_pkg::HOLD_BIT] = s[7];
    status_word[bvp_pkg::SCHEME_LSB +: bvp_pkg::SCHEME_W] = s[9:8];
    status_word[bvp_pkg::STK0_LSB +: bvp_pkg::STK01_W] = s[11:10];
    status_word[bvp_pkg::STK1_LSB +: bvp_pkg::STK01_W] = s[13:12];
    status_word[bvp_pkg::STK2_LSB +: bvp_pkg::STK23_W] = s[18:14];
    status_word[bvp_pkg::STK3_LSB +: bvp_pkg::STK23_W] = s[23:19];
  end

  // ****************************************
  // Clock select register
  // ****************************************
  // Status register has no write path at all, so writes to it are dropped
  assign cfg.wr_en   = i_wr && (i_addr == bvp_pkg::OFS_CLK_SEL);
  assign cfg.wr_data = i_wdata[bvp_pkg::CLK_SEL_W-1:0];

  bvp_clock_select u_sel (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .cfg        (cfg.regs)
  );

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    next_rdata = bvp_pkg::ZERO_WORD;
    case (i_addr)
      bvp_pkg::OFS_STATUS:  next_rdata = status_word;
      bvp_pkg::OFS_CLK_SEL: next_rdata = {16'h0000, cfg.clk_sel};
      default:              next_rdata = bvp_pkg::ZERO_WORD;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= bvp_pkg::ZERO_WORD;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= bvp_pkg::ZERO_WORD;
    end
  end

  // ****************************************
  // Per-port clock steering
  // ****************************************
  // Pairs for ports 0-7, groups of four for 8-23; reserved codes fall back to global
  genvar p;
  generate
    for (p = 0; p < bvp_pkg::NUM_PORTS; p++) begin : g_port
      localparam int GRP = (p < 8) ? (p / 2) : (4 + (p - 8) / 4);
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_port_local_clock[p] <= 1'b0;
        end else begin
          o_port_local_clock[p] <=
            (cfg.clk_sel[GRP*bvp_pkg::SEL_W +: bvp_pkg::SEL_W] == bvp_pkg::SEL_LOCAL);
        end
      end
    end
  endgenerate

  // ****************************************
  // Reset hold
  // ****************************************
  // Held from reset until the strap is seen clear or software releases it;
  // the register port stays live throughout so software can initialise.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold <= 1'b1;
    end else if (i_reset_hold_release) begin
      hold <= 1'b0;
    end else if (cfg.straps_valid && !s[7]) begin
      hold <= 1'b0;
    end
  end

  assign o_switch_hold = hold;
endmodule : bvp_regs
`default_nettype wire

// ===== bench/bvp_regs_props.sv
// Concurrent checks on the register bank ports.
// Assumes it is bound to bvp_regs and sees only that module's ports.
`default_nettype none
module bvp_regs_props (
  input wire logic                          i_core_clk,
  input wire logic                          i_rst_n,
  input wire logic                          i_reset_hold_strap,
  input wire logic                          i_reset_hold_release,
  input wire logic [bvp_pkg::ADDR_W-1:0]    i_addr,
  input wire logic [bvp_pkg::DATA_W-1:0]    i_wdata,
  input wire logic                          i_wr,
  input wire logic                          i_rd,
  input wire logic [bvp_pkg::DATA_W-1:0]    o_rdata,
  input wire logic [bvp_pkg::NUM_PORTS-1:0] o_port_local_clock,
  input wire logic                          o_switch_hold
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic sel_wr = i_wr && i_addr == 12'h008;

  // Ports 0-7 go in pairs, 8-23 in fours; only code 1 means local
  function automatic logic [23:0] pmap(input logic [31:0] w);
    logic [23:0] p;
    int          g;
    for (int n = 0; n < 24; n++) begin
      g = (n < 8) ? n / 2 : 4 + (n - 8) / 4;
      p[n] = (w[2*g+:2] == 2'h1);
    end
    return p;
  endfunction : pmap

  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside read cycle");
  a_status_rsvd_zero: assert property ($past(i_rd) && $past(i_addr) == 12'h004
    |-> {o_rdata[31:30], o_rdata[13:10], o_rdata[6], o_rdata[4]} == 8'h00)
    else $error("status reserved bits not zero");
  a_sel_rsvd_zero: assert property ($past(i_rd) && $past(i_addr) == 12'h008
    |-> o_rdata[31:16] == 16'h0000) else $error("select upper half not zero");
  a_unmapped_read_zero: assert property ($past(i_rd) && $past(i_addr) != 12'h004
    && $past(i_addr) != 12'h008 |-> o_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_port_group_map: assert property (sel_wr ##1 !sel_wr
    |=> o_port_local_clock == pmap($past(i_wdata, 2))) else $error("port steering wrong");
  a_sel_holds_value: assert property (!sel_wr [*2] |=> $stable(o_port_local_clock))
    else $error("port steering changed without write");
  a_sel_readback: assert property (sel_wr ##1 (i_rd && i_addr == 12'h008)
    |=> o_rdata == {16'h0000, $past(i_wdata[15:0], 2)}) else $error("select readback wrong");
  a_hold_needs_cause: assert property ($fell(o_switch_hold) |-> !i_reset_hold_strap
    || $past(i_reset_hold_release) || $past(i_reset_hold_release, 2))
    else $error("hold dropped without cause");
  a_hold_stays_off: assert property (!o_switch_hold |=> !o_switch_hold)
    else $error("hold came back without reset");
endmodule : bvp_regs_props

bind bvp_regs bvp_regs_props u_props (
  .i_core_clk, .i_rst_n, .i_reset_hold_strap, .i_reset_hold_release, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .o_port_local_clock, .o_switch_hold
);
`default_nettype wire

// ===== bench/tb_boot_vector_and_port_clock_regs.sv
// Self-checking bench for the boot strap status and clock select registers.
// Assumes bvp_regs with its plain strobe port, and the bound checker.
`default_nettype none
`define BVP_CHECK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %s expected %h seen %h", nm, (e), (g)); end end
module tb_boot_vector_and_port_clock_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_core_clk = 1'h0;
  logic        i_rst_n = 1'h0;
  logic [3:0]  mode = 4'hA;
  logic        fsel = 1'h1, hold = 1'h1, rel = 1'h0, wr = 1'h0, rd = 1'h0, hold_o;
  logic [1:0]  saddr = 2'h2, sch = 2'h3, s0 = 2'h1, s1 = 2'h2;
  logic [4:0]  s2 = 5'h15, s3 = 5'h0A;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, rv, w;
  logic [23:0] ports;
  int          fail_count = 0, num_checks = 0;

  bvp_regs DUT (.i_core_clk, .i_rst_n, .i_switch_operating_mode(mode),
    .i_global_clock_freq_select(fsel), .i_mgmt_slave_address(saddr),
    .i_reset_hold_strap(hold), .i_ref_clock_scheme(sch), .i_stack0_initial_config(s0),
    .i_stack1_initial_config(s1), .i_stack2_initial_config(s2),
    .i_stack3_initial_config(s3), .i_reset_hold_release(rel), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_port_local_clock(ports),
    .o_switch_hold(hold_o));

  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end

  function automatic logic [23:0] pmap(input logic [31:0] v);
    logic [23:0] p;
    int          g;
    for (int n = 0; n < 24; n++) begin
      g = (n < 8) ? n / 2 : 4 + (n - 8) / 4;
      p[n] = (v[2*g+:2] == 2'h1);
    end
    return p;
  endfunction : pmap

  function automatic logic [31:0] stat_exp();
    return {2'h0, s3, s2, s1, s0, sch, 4'h0, hold, saddr, 1'h0, fsel, 1'h0, mode};
  endfunction : stat_exp

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // Called just after a rising edge, so a write then a read are back to back
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    wr    <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge i_core_clk);
    wr    <= 1'h0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so take them mid-cycle
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    rd   <= 1'h1;
    addr <= a;
    @(posedge i_core_clk);
    rd   <= 1'h0;
    @(negedge i_core_clk);
    d = rdata;
    @(posedge i_core_clk);
  endtask : rd_reg

  // Bounded wait; a hang ends the run rather than stalling it
  task automatic wait_hold_low();
    for (int n = 0; n < 8 && hold_o !== 1'h0; n++) @(negedge i_core_clk);
    `BVP_CHECK("switch hold", 1'h0, hold_o)
    if (hold_o !== 1'h0) summarize();
    @(posedge i_core_clk);
  endtask : wait_hold_low

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_hold();
    repeat (4) @(negedge i_core_clk);
    `BVP_CHECK("hold while strap set", 1'h1, hold_o)
    @(posedge i_core_clk);
    rel <= 1'h1;
    @(posedge i_core_clk);
    rel <= 1'h0;
    wait_hold_low();
    $display("t_hold done");
  endtask : t_hold

  task automatic t_status();
    rd_reg(12'h004, rv);
    `BVP_CHECK("status", stat_exp(), rv)
    w = stat_exp();
    {mode, fsel, saddr, sch, s0, s1, s2, s3} <= ~{mode, fsel, saddr, sch, s0, s1, s2, s3};
    wr_reg(12'h004, 32'hFFFF_FFFF);
    rd_reg(12'h004, rv);
    `BVP_CHECK("status after write", w, rv)
    $display("t_status done");
  endtask : t_status

  task automatic t_clk_sel();
    rd_reg(12'h008, rv);
    `BVP_CHECK("select reset", 32'h0000_0000, rv)
    `BVP_CHECK("ports reset", 24'h00_0000, ports)
    for (int k = 0; k < 12; k++) begin
      w = (k < 8) ? 32'h0000_0001 << (2 * k) : {32'hFFFF_5555, 32'h0000_AAAA,
        32'h0000_FFFF, 32'h0000_1E4D} >> (32 * (11 - k));
      wr_reg(12'h008, w);
      rd_reg(12'h008, rv);
      `BVP_CHECK("select readback", {16'h0000, w[15:0]}, rv)
      `BVP_CHECK("port steering", pmap(w), ports)
    end
    $display("t_clk_sel done");
  endtask : t_clk_sel

  task automatic t_unmapped();
    wr_reg(12'h00C, 32'hFFFF_FFFF);
    rd_reg(12'h00C, rv);
    `BVP_CHECK("unmapped read", 32'h0000_0000, rv)
    rd_reg(12'h008, rv);
    `BVP_CHECK("select kept", 32'h0000_1E4D, rv)
    $display("t_unmapped done");
  endtask : t_unmapped

  task automatic t_fund_reset();
    @(posedge i_core_clk);
    i_rst_n <= 1'h0;
    hold <= 1'h0;
    mode <= 4'h3;
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'h1;
    wait_hold_low();
    rd_reg(12'h008, rv);
    `BVP_CHECK("select after reset", 32'h0000_0000, rv)
    `BVP_CHECK("ports after reset", 24'h00_0000, ports)
    rd_reg(12'h004, rv);
    `BVP_CHECK("status recaptured", stat_exp(), rv)
    $display("t_fund_reset done");
  endtask : t_fund_reset

  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'h1;
    repeat (3) @(posedge i_core_clk);
    t_hold();
    t_status();
    t_clk_sel();
    t_unmapped();
    t_fund_reset();
    summarize();
  end
endmodule : tb_boot_vector_and_port_clock_regs
`default_nettype wire
